// file: hw/dsra_pkg.sv
/*
 * Shared constants, types and helpers of the dual slave register access
 * front end: data and address widths, word indices, response codes and
 * the per-port control states.
 * Assumes one clock domain and a 4 KB address window on each slave port.
 */
package dsra_pkg;

	// ==========================================================================
	// Widths and fixed indices
	// ==========================================================================
	localparam int DSRA_DATA_W = 32;
	localparam int DSRA_STRB_W = 4;
	localparam int DSRA_ADDR_W = 12;
	localparam int DSRA_IDX_W = 10;
	localparam int DSRA_BANK_W = 3;
	localparam int DSRA_MAX_CPU = 8;
	localparam int DSRA_NUM_PORTS = 2;
	localparam int DSRA_PORT_D = 0;
	localparam int DSRA_PORT_C = 1;
	localparam int DSRA_HTRANS_ACT_BIT = 1;
	localparam logic [DSRA_IDX_W-1:0] DSRA_STAT_IDX = 10'h3ff;
	localparam logic [1:0] DSRA_RESP_OKAY = 2'h0;
	localparam logic [DSRA_DATA_W-1:0] DSRA_RESET_WORD = 32'h0;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_AW = 3'b001,
		S_W = 3'b010,
		S_B = 3'b011,
		S_AR = 3'b100,
		S_R = 3'b101
	} dsra_state_e;

	// One register write as it reaches the storage
	typedef struct packed {
		logic en;
		logic hit;
		logic [DSRA_BANK_W-1:0] bank;
		logic [DSRA_IDX_W-1:0] idx;
		logic [DSRA_STRB_W-1:0] strb;
		logic [DSRA_DATA_W-1:0] data;
	} dsra_wr_s;

	// ==========================================================================
	// Byte lanes of a narrow single-beat bus access
	// ==========================================================================
	function automatic logic [DSRA_STRB_W-1:0] dsra_lanes(
		input logic [2:0] size,
		input logic [1:0] lo
	);
		logic [DSRA_STRB_W-1:0] l;
		unique case (size)
			3'h0: l = 4'h1 << lo;
			3'h1: l = lo[1] ? 4'hc : 4'h3;
			default: l = 4'hf;
		endcase
		return l;
	endfunction

endpackage

// file: hw/dsra_id_match.sv
/*
 * Transaction ID to CPU interface bank selector: masks the ID with each
 * per-interface enable and compares it with the per-interface match value.
 * Assumes the integrator keeps at most one bank matching for any live ID;
 * if several match, the lowest numbered bank is taken.
 */
module dsra_id_match
	import dsra_pkg::*;
#(
	parameter int ID_W = 8,
	parameter int NCPU = 8
) (
	input wire logic [ID_W-1:0] id_i,
	input wire logic [NCPU-1:0][ID_W-1:0] enable_i,
	input wire logic [NCPU-1:0][ID_W-1:0] match_i,
	output logic hit_o,
	output logic [DSRA_BANK_W-1:0] bank_o
);

	// ==========================================================================
	// Bank search
	// ==========================================================================
	// Scan high to low so the lowest matching bank ends up selected
	always_comb begin
		hit_o = 1'b0;
		bank_o = '0;
		for (int n = NCPU - 1; n >= 0; n--) begin
			if ((id_i & enable_i[n]) == match_i[n]) begin
				hit_o = 1'b1;
				bank_o = DSRA_BANK_W'(n);
			end
		end
	end

endmodule // dsra_id_match

// file: hw/dsra_reg_front.sv
/*
 * Register access front end of an interrupt controller: a distributor port
 * (suffix _d) and a port shared by the CPU interfaces (suffix _c), each an
 * AXI or AHB-Lite slave, backed by flip-flop register storage.
 * Assumes single-beat AXI accesses and same-clock inputs everywhere.
 */
module dsra_reg_front
	import dsra_pkg::*;
#(
	parameter bit use_ahb = 1'b0,
	parameter int ncpu = 8,
	parameter int bank_words = 8,
	parameter int shared_words = 64,
	parameter int dist_port_id_bits = 8,
	parameter int cpuif_port_id_bits = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic awvalid_d_i,
	output logic awready_d_o,
	input wire logic [dist_port_id_bits-1:0] awid_d_i,
	input wire logic [DSRA_ADDR_W-1:0] awaddr_d_i,
	input wire logic wvalid_d_i,
	output logic wready_d_o,
	input wire logic [DSRA_DATA_W-1:0] wdata_d_i,
	input wire logic [DSRA_STRB_W-1:0] wstrb_d_i,
	output logic bvalid_d_o,
	input wire logic bready_d_i,
	output logic [dist_port_id_bits-1:0] bid_d_o,
	output logic [1:0] bresp_d_o,
	input wire logic arvalid_d_i,
	output logic arready_d_o,
	input wire logic [dist_port_id_bits-1:0] arid_d_i,
	input wire logic [DSRA_ADDR_W-1:0] araddr_d_i,
	output logic rvalid_d_o,
	input wire logic rready_d_i,
	output logic [dist_port_id_bits-1:0] rid_d_o,
	output logic [DSRA_DATA_W-1:0] rdata_d_o,
	output logic [1:0] rresp_d_o,
	output logic rlast_d_o,
	input wire logic hsel_d_i,
	input wire logic [DSRA_ADDR_W-1:0] haddr_d_i,
	input wire logic [1:0] htrans_d_i,
	input wire logic hwrite_d_i,
	input wire logic [2:0] hsize_d_i,
	input wire logic [DSRA_DATA_W-1:0] hwdata_d_i,
	input wire logic hready_d_i,
	output logic hreadyout_d_o,
	output logic [DSRA_DATA_W-1:0] hrdata_d_o,
	output logic hresp_d_o,
	input wire logic [ncpu-1:0][dist_port_id_bits-1:0] enable_d_i,
	input wire logic [ncpu-1:0][dist_port_id_bits-1:0] match_d_i,
	input wire logic [DSRA_DATA_W-1:0] status_d_i,
	input wire logic awvalid_c_i,
	output logic awready_c_o,
	input wire logic [cpuif_port_id_bits-1:0] awid_c_i,
	input wire logic [DSRA_ADDR_W-1:0] awaddr_c_i,
	input wire logic wvalid_c_i,
	output logic wready_c_o,
	input wire logic [DSRA_DATA_W-1:0] wdata_c_i,
	input wire logic [DSRA_STRB_W-1:0] wstrb_c_i,
	output logic bvalid_c_o,
	input wire logic bready_c_i,
	output logic [cpuif_port_id_bits-1:0] bid_c_o,
	output logic [1:0] bresp_c_o,
	input wire logic arvalid_c_i,
	output logic arready_c_o,
	input wire logic [cpuif_port_id_bits-1:0] arid_c_i,
	input wire logic [DSRA_ADDR_W-1:0] araddr_c_i,
	output logic rvalid_c_o,
	input wire logic rready_c_i,
	output logic [cpuif_port_id_bits-1:0] rid_c_o,
	output logic [DSRA_DATA_W-1:0] rdata_c_o,
	output logic [1:0] rresp_c_o,
	output logic rlast_c_o,
	input wire logic hsel_c_i,
	input wire logic [DSRA_ADDR_W-1:0] haddr_c_i,
	input wire logic [1:0] htrans_c_i,
	input wire logic hwrite_c_i,
	input wire logic [2:0] hsize_c_i,
	input wire logic [DSRA_DATA_W-1:0] hwdata_c_i,
	input wire logic hready_c_i,
	output logic hreadyout_c_o,
	output logic [DSRA_DATA_W-1:0] hrdata_c_o,
	output logic hresp_c_o,
	input wire logic [ncpu-1:0][cpuif_port_id_bits-1:0] enable_c_i,
	input wire logic [ncpu-1:0][cpuif_port_id_bits-1:0] match_c_i,
	input wire logic [DSRA_DATA_W-1:0] status_c_i
);

	localparam int ID_MAX = (dist_port_id_bits > cpuif_port_id_bits) ?
		dist_port_id_bits : cpuif_port_id_bits;

	// ==========================================================================
	// Build checks
	// ==========================================================================
	if (ncpu < 1 || ncpu > DSRA_MAX_CPU || bank_words < 1 ||
		bank_words + shared_words > int'(DSRA_STAT_IDX) ||
		dist_port_id_bits < 1 || cpuif_port_id_bits < 1 ||
		(use_ahb && ncpu != 1)) begin : g_bad_cfg
		$error("dsra_reg_front: unsupported parameter set");
	end

	// ==========================================================================
	// Port gathering, index 0 distributor and 1 CPU interfaces
	// ==========================================================================
	logic [1:0] awvalid_w, wvalid_w, bready_w, arvalid_w, rready_w;
	logic [1:0] hsel_w, hwrite_w, hready_w;
	logic [1:0][ID_MAX-1:0] awid_w, arid_w;
	logic [1:0][DSRA_ADDR_W-1:0] awaddr_w, araddr_w, haddr_w;
	logic [1:0][DSRA_DATA_W-1:0] wdata_w, hwdata_w, status_w;
	logic [1:0][DSRA_STRB_W-1:0] wstrb_w;
	logic [1:0][1:0] htrans_w;
	logic [1:0][2:0] hsize_w;
	logic [1:0][ncpu-1:0][ID_MAX-1:0] en_w, mt_w;
	logic [1:0] awready_q, wready_q, bvalid_q, arready_q, rvalid_q, hrdy_q;
	logic [1:0][ID_MAX-1:0] id_q;
	logic [1:0][DSRA_DATA_W-1:0] rdata_q;
	logic [1:0][1:0] resp_q;

	assign awvalid_w = {awvalid_c_i, awvalid_d_i};
	assign wvalid_w = {wvalid_c_i, wvalid_d_i};
	assign bready_w = {bready_c_i, bready_d_i};
	assign arvalid_w = {arvalid_c_i, arvalid_d_i};
	assign rready_w = {rready_c_i, rready_d_i};
	assign hsel_w = {hsel_c_i, hsel_d_i};
	assign hwrite_w = {hwrite_c_i, hwrite_d_i};
	assign hready_w = {hready_c_i, hready_d_i};
	assign awid_w = {ID_MAX'(awid_c_i), ID_MAX'(awid_d_i)};
	assign arid_w = {ID_MAX'(arid_c_i), ID_MAX'(arid_d_i)};
	assign awaddr_w = {awaddr_c_i, awaddr_d_i};
	assign araddr_w = {araddr_c_i, araddr_d_i};
	assign haddr_w = {haddr_c_i, haddr_d_i};
	assign wdata_w = {wdata_c_i, wdata_d_i};
	assign hwdata_w = {hwdata_c_i, hwdata_d_i};
	assign status_w = {status_c_i, status_d_i};
	assign wstrb_w = {wstrb_c_i, wstrb_d_i};
	assign htrans_w = {htrans_c_i, htrans_d_i};
	assign hsize_w = {hsize_c_i, hsize_d_i};

	// ID masks widened to the common ID width
	for (genvar n = 0; n < ncpu; n++) begin : g_idw
		assign en_w[0][n] = ID_MAX'(enable_d_i[n]);
		assign mt_w[0][n] = ID_MAX'(match_d_i[n]);
		assign en_w[1][n] = ID_MAX'(enable_c_i[n]);
		assign mt_w[1][n] = ID_MAX'(match_c_i[n]);
	end

	// ==========================================================================
	// Per-port slave engine and register storage
	// ==========================================================================
	for (genvar p = 0; p < DSRA_NUM_PORTS; p++) begin : g_port
		localparam int SHARED = (p == DSRA_PORT_D) ? shared_words : 0;
		localparam int NW = ncpu * bank_words + SHARED;

		typedef struct packed {
			dsra_state_e st;
			logic awready;
			logic wready;
			logic bvalid;
			logic arready;
			logic rvalid;
			logic hreadyout;
			logic [1:0] resp;
			logic [ID_MAX-1:0] id;
			logic hit;
			logic [DSRA_BANK_W-1:0] bank;
			logic [DSRA_IDX_W-1:0] idx;
			logic [DSRA_DATA_W-1:0] rdata;
			logic ahb_wr;
			logic [DSRA_STRB_W-1:0] ahb_strb;
			logic [NW-1:0][DSRA_DATA_W-1:0] mem;
		} dsra_port_s;

		dsra_port_s s, next_s;
		dsra_wr_s wr;
		logic [ID_MAX-1:0] look_id;
		logic m_hit, ahb_take;
		logic [DSRA_BANK_W-1:0] m_bank;
		int k;

		// Storage slot of a word index, or -1 when nothing answers there
		function automatic int slot(input logic [DSRA_IDX_W-1:0] i,
			input logic h, input logic [DSRA_BANK_W-1:0] b);
			if (int'(i) < bank_words) begin
				return h ? int'(b) * bank_words + int'(i) : -1;
			end
			if (int'(i) - bank_words < SHARED) begin
				return ncpu * bank_words + int'(i) - bank_words;
			end
			return -1;
		endfunction

		// Read value: status word, stored word, or zero
		function automatic logic [DSRA_DATA_W-1:0] rd(
			input logic [NW-1:0][DSRA_DATA_W-1:0] m,
			input logic [DSRA_IDX_W-1:0] i, input logic h,
			input logic [DSRA_BANK_W-1:0] b);
			int j;
			j = slot(i, h, b);
			if (i == DSRA_STAT_IDX) begin
				return status_w[p];
			end
			return (j < 0) ? DSRA_RESET_WORD : m[j];
		endfunction

		// The ID under test follows the address channel being served
		assign look_id = (s.st == S_AR) ? arid_w[p] : awid_w[p];

		dsra_id_match #(
			.ID_W(ID_MAX),
			.NCPU(ncpu)
		) u_match (
			.id_i(look_id),
			.enable_i(en_w[p]),
			.match_i(mt_w[p]),
			.hit_o(m_hit),
			.bank_o(m_bank)
		);

		// Next state: bus handshakes and AXI reads, then the register write, then AHB reads
		always_comb begin
			next_s = s;
			next_s.hreadyout = 1'b1;
			next_s.resp = DSRA_RESP_OKAY;
			wr = '{en: 1'b0, hit: s.hit, bank: s.bank, idx: s.idx,
				strb: wstrb_w[p], data: wdata_w[p]};
			ahb_take = use_ahb && hsel_w[p] && hready_w[p] &&
				htrans_w[p][DSRA_HTRANS_ACT_BIT];
			if (use_ahb) begin
				if (s.ahb_wr) begin
					wr = '{en: 1'b1, hit: 1'b1, bank: '0, idx: s.idx,
						strb: s.ahb_strb, data: hwdata_w[p]};
				end
				next_s.ahb_wr = ahb_take && hwrite_w[p];
				if (ahb_take) begin
					next_s.idx = haddr_w[p][DSRA_ADDR_W-1:2];
					next_s.ahb_strb = dsra_lanes(hsize_w[p],
						haddr_w[p][1:0]);
				end
			end else begin
				unique case (s.st)
					S_IDLE: begin
						if (awvalid_w[p]) begin
							next_s.st = S_AW;
							next_s.awready = 1'b1;
						end else if (arvalid_w[p]) begin
							next_s.st = S_AR;
							next_s.arready = 1'b1;
						end
					end
					S_AW: begin
						if (awvalid_w[p]) begin
							next_s.awready = 1'b0;
							next_s.wready = 1'b1;
							next_s.id = look_id;
							next_s.hit = m_hit;
							next_s.bank = m_bank;
							next_s.idx = awaddr_w[p][DSRA_ADDR_W-1:2];
							next_s.st = S_W;
						end
					end
					S_W: begin
						if (wvalid_w[p]) begin
							wr.en = 1'b1;
							next_s.wready = 1'b0;
							next_s.bvalid = 1'b1;
							next_s.st = S_B;
						end
					end
					S_B: begin
						if (bready_w[p]) begin
							next_s.bvalid = 1'b0;
							next_s.st = S_IDLE;
						end
					end
					S_AR: begin
						if (arvalid_w[p]) begin
							next_s.arready = 1'b0;
							next_s.id = look_id;
							next_s.rdata = rd(s.mem,
								araddr_w[p][DSRA_ADDR_W-1:2], m_hit, m_bank);
							next_s.rvalid = 1'b1;
							next_s.st = S_R;
						end
					end
					S_R: begin
						if (rready_w[p]) begin
							next_s.rvalid = 1'b0;
							next_s.st = S_IDLE;
						end
					end
					default: begin
						next_s.st = S_IDLE;
					end
				endcase
			end
			k = slot(wr.idx, wr.hit, wr.bank);
			if (wr.en && k >= 0) begin
				for (int b = 0; b < DSRA_STRB_W; b++) begin
					if (wr.strb[b]) begin
						next_s.mem[k][8*b +: 8] = wr.data[8*b +: 8];
					end
				end
			end
			// Read after the data-phase write so back-to-back stays coherent
			if (ahb_take && !hwrite_w[p]) begin
				next_s.rdata = rd(next_s.mem,
					haddr_w[p][DSRA_ADDR_W-1:2], 1'b1, '0);
			end
		end

		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				s <= '0;
			end else if (ce_i) begin
				s <= next_s;
			end
		end

		assign awready_q[p] = s.awready;
		assign wready_q[p] = s.wready;
		assign bvalid_q[p] = s.bvalid;
		assign arready_q[p] = s.arready;
		assign rvalid_q[p] = s.rvalid;
		assign hrdy_q[p] = s.hreadyout;
		assign id_q[p] = s.id;
		assign rdata_q[p] = s.rdata;
		assign resp_q[p] = s.resp;
	end

	// ==========================================================================
	// Outputs, all straight from the port state flops
	// ==========================================================================
	// distributor port, then CPU interface port
	assign awready_d_o = awready_q[0];
	assign wready_d_o = wready_q[0];
	assign bvalid_d_o = bvalid_q[0];
	assign bid_d_o = id_q[0][dist_port_id_bits-1:0];
	assign bresp_d_o = resp_q[0];
	assign arready_d_o = arready_q[0];
	assign rvalid_d_o = rvalid_q[0];
	assign rid_d_o = id_q[0][dist_port_id_bits-1:0];
	assign rdata_d_o = rdata_q[0];
	assign rresp_d_o = resp_q[0];
	assign rlast_d_o = rvalid_q[0];
	assign hreadyout_d_o = hrdy_q[0];
	assign hrdata_d_o = rdata_q[0];
	assign hresp_d_o = resp_q[0][0];
	assign awready_c_o = awready_q[1];
	assign wready_c_o = wready_q[1];
	assign bvalid_c_o = bvalid_q[1];
	assign bid_c_o = id_q[1][cpuif_port_id_bits-1:0];
	assign bresp_c_o = resp_q[1];
	assign arready_c_o = arready_q[1];
	assign rvalid_c_o = rvalid_q[1];
	assign rid_c_o = id_q[1][cpuif_port_id_bits-1:0];
	assign rdata_c_o = rdata_q[1];
	assign rresp_c_o = resp_q[1];
	assign rlast_c_o = rvalid_q[1];
	assign hreadyout_c_o = hrdy_q[1];
	assign hrdata_c_o = rdata_q[1];
	assign hresp_c_o = resp_q[1][0];

endmodule // dsra_reg_front

// file: tb/dsra_axi_master.sv
/*
 * Behavioural AXI master for one slave port: single-beat writes and
 * reads, with an optional lag before it takes a response.
 * Assumes the slave samples on the rising edge; drives at falling edges.
 */
module dsra_axi_master #(
	parameter int id_bits = 8
) (
	input wire logic clk_i,
	output logic awv_o,
	input wire logic awr_i,
	output logic [id_bits-1:0] awid_o,
	output logic [11:0] awa_o,
	output logic wv_o,
	input wire logic wr_i,
	output logic [31:0] wd_o,
	output logic [3:0] ws_o,
	input wire logic bv_i,
	output logic br_o,
	input wire logic [id_bits-1:0] bid_i,
	input wire logic [1:0] bre_i,
	output logic arv_o,
	input wire logic arr_i,
	output logic [id_bits-1:0] arid_o,
	output logic [11:0] ara_o,
	input wire logic rv_i,
	output logic rr_o,
	input wire logic [id_bits-1:0] rid_i,
	input wire logic [31:0] rd_i,
	input wire logic [1:0] rre_i
);
	timeunit 1ns;
	timeprecision 1ps;
	int lag = 0;

	// Idle levels from time zero
	initial begin
		{awv_o, wv_o, br_o, arv_o, rr_o} = '0;
		{awid_o, awa_o, wd_o, ws_o, arid_o, ara_o} = '0;
	end

	// One write: address and data offered together, then the response
	task automatic write(input logic [id_bits-1:0] id,
		input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp, output logic [id_bits-1:0] id_seen);
		@(negedge clk_i);
		awid_o = id;
		awa_o = a;
		awv_o = 1'b1;
		wd_o = d;
		ws_o = s;
		wv_o = 1'b1;
		br_o = (lag == 0);
		do @(posedge clk_i); while (!awr_i);
		@(negedge clk_i);
		awv_o = 1'b0;
		awa_o = ~a;
		awid_o = ~id;
		do @(posedge clk_i); while (!wr_i);
		@(negedge clk_i);
		wv_o = 1'b0;
		wd_o = ~d;
		do @(posedge clk_i); while (!bv_i);
		if (lag > 0) begin
			repeat (lag) @(negedge clk_i);
			br_o = 1'b1;
			@(posedge clk_i);
		end
		resp = bre_i;
		id_seen = bid_i;
		@(negedge clk_i);
		br_o = 1'b0;
	endtask

	// One read: address, then the data beat
	task automatic read(input logic [id_bits-1:0] id, input logic [11:0] a,
		output logic [31:0] d, output logic [1:0] resp,
		output logic [id_bits-1:0] id_seen);
		@(negedge clk_i);
		arid_o = id;
		ara_o = a;
		arv_o = 1'b1;
		rr_o = (lag == 0);
		do @(posedge clk_i); while (!arr_i);
		@(negedge clk_i);
		arv_o = 1'b0;
		ara_o = ~a;
		arid_o = ~id;
		do @(posedge clk_i); while (!rv_i);
		if (lag > 0) begin
			repeat (lag) @(negedge clk_i);
			rr_o = 1'b1;
			@(posedge clk_i);
		end
		d = rd_i;
		resp = rre_i;
		id_seen = rid_i;
		@(negedge clk_i);
		rr_o = 1'b0;
	endtask
endmodule // dsra_axi_master

// file: tb/dsra_reg_front_checker.sv
/*
 * Protocol checker on the distributor AXI port of the front end.
 * Assumes the AXI build and the clock enable held high.
 */
module dsra_reg_front_checker
	import dsra_pkg::*;
#(
	parameter int dist_port_id_bits = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic awvalid_d_i,
	input wire logic awready_d_o,
	input wire logic [dist_port_id_bits-1:0] awid_d_i,
	input wire logic wvalid_d_i,
	input wire logic wready_d_o,
	input wire logic bvalid_d_o,
	input wire logic bready_d_i,
	input wire logic [dist_port_id_bits-1:0] bid_d_o,
	input wire logic [1:0] bresp_d_o,
	input wire logic arvalid_d_i,
	input wire logic arready_d_o,
	input wire logic rvalid_d_o,
	input wire logic rready_d_i,
	input wire logic rlast_d_o,
	input wire logic [1:0] rresp_d_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [dist_port_id_bits-1:0] aw_id;

	// Remember the ID of the accepted write address
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			aw_id <= '0;
		else if (awvalid_d_i && awready_d_o)
			aw_id <= awid_d_i;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// ==========================================================================
	// Handshake order
	// ==========================================================================
	property p_single_accept;
		awready_d_o |-> !arready_d_o;
	endproperty
	a_single_accept: assert property (p_single_accept)
		else $error("read and write accepted together");
	property p_w_after_aw;
		awvalid_d_i && awready_d_o |=> wready_d_o && !awready_d_o;
	endproperty
	a_w_after_aw: assert property (p_w_after_aw)
		else $error("write data not taken after address");
	property p_b_after_w;
		wvalid_d_i && wready_d_o |=> bvalid_d_o && bresp_d_o == DSRA_RESP_OKAY;
	endproperty
	a_b_after_w: assert property (p_b_after_w)
		else $error("no okay response after write data");
	property p_b_hold;
		bvalid_d_o && !bready_d_i |=> bvalid_d_o && $stable(bid_d_o);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_bid_echo;
		bvalid_d_o |-> bid_d_o == aw_id;
	endproperty
	a_bid_echo: assert property (p_bid_echo)
		else $error("write response id differs");
	property p_r_after_ar;
		arvalid_d_i && arready_d_o |=> rvalid_d_o && rlast_d_o
			&& rresp_d_o == DSRA_RESP_OKAY;
	endproperty
	a_r_after_ar: assert property (p_r_after_ar)
		else $error("read beat missing after address");
	property p_r_hold;
		rvalid_d_o && !rready_d_i |=> rvalid_d_o;
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read beat dropped early");
	property p_busy_refuse;
		bvalid_d_o || rvalid_d_o || wready_d_o |-> !awready_d_o && !arready_d_o;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse)
		else $error("new address accepted while busy");
	property p_b_single;
		bvalid_d_o && bready_d_i |=> !bvalid_d_o;
	endproperty
	a_b_single: assert property (p_b_single)
		else $error("write response repeated");
endmodule // dsra_reg_front_checker

bind dsra_reg_front dsra_reg_front_checker
	#(.dist_port_id_bits(dist_port_id_bits)) u_checker (.*);

// file: tb/tb.sv
/*
 * Testbench top: AXI build with two CPU interfaces and narrow IDs, one
 * master model on each of its ports, plus a one-interface AHB-Lite build.
 * Assumes the package, design, master model and checker compiled first.
 */
module tb import dsra_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, reset_n_i, ce_i;
	logic awvalid_d_i, awready_d_o, wvalid_d_i, wready_d_o, bvalid_d_o;
	logic bready_d_i, arvalid_d_i, arready_d_o, rvalid_d_o, rready_d_i;
	logic awvalid_c_i, awready_c_o, wvalid_c_i, wready_c_o, bvalid_c_o;
	logic bready_c_i, arvalid_c_i, arready_c_o, rvalid_c_o, rready_c_i;
	logic rlast_d_o, rlast_c_o, hreadyout_d_o, hreadyout_c_o, ahb_ready;
	logic [31:0] ahb_rdata;
	logic hsel_d_i, hwrite_d_i, hready_d_i, hresp_d_o;
	logic hsel_c_i, hwrite_c_i, hready_c_i, hresp_c_o;
	logic [3:0] awid_d_i, bid_d_o, arid_d_i, rid_d_o, wstrb_d_i, wstrb_c_i;
	logic [2:0] awid_c_i, bid_c_o, arid_c_i, rid_c_o, hsize_d_i, hsize_c_i;
	logic [11:0] awaddr_d_i, araddr_d_i, awaddr_c_i, araddr_c_i;
	logic [11:0] haddr_d_i, haddr_c_i;
	logic [31:0] wdata_d_i, rdata_d_o, hwdata_d_i, hrdata_d_o, status_d_i;
	logic [31:0] wdata_c_i, rdata_c_o, hwdata_c_i, hrdata_c_o, status_c_i;
	logic [1:0] bresp_d_o, rresp_d_o, htrans_d_i;
	logic [1:0] bresp_c_o, rresp_c_o, htrans_c_i;
	logic [1:0][3:0] enable_d_i, match_d_i;
	logic [1:0][2:0] enable_c_i, match_c_i;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;

	dsra_reg_front #(.ncpu(2), .dist_port_id_bits(4),
		.cpuif_port_id_bits(3)) dut (.*);

	// AHB-Lite build
	dsra_reg_front #(.use_ahb(1'b1), .ncpu(1), .dist_port_id_bits(4),
		.cpuif_port_id_bits(3)) dut_ahb (.*, .enable_d_i(enable_d_i[0]),
		.match_d_i(match_d_i[0]), .enable_c_i(enable_c_i[0]),
		.match_c_i(match_c_i[0]), .hreadyout_d_o(ahb_ready),
		.hrdata_d_o(ahb_rdata), .hresp_d_o(), .awready_d_o(),
		.wready_d_o(), .bvalid_d_o(), .bid_d_o(), .bresp_d_o(),
		.arready_d_o(), .rvalid_d_o(), .rid_d_o(), .rdata_d_o(),
		.rresp_d_o(), .rlast_d_o(), .awready_c_o(), .wready_c_o(),
		.bvalid_c_o(), .bid_c_o(), .bresp_c_o(), .arready_c_o(),
		.rvalid_c_o(), .rid_c_o(), .rdata_c_o(), .rresp_c_o(),
		.rlast_c_o(), .hreadyout_c_o(), .hrdata_c_o(), .hresp_c_o());

	// Masters on the distributor and CPU interface ports
	dsra_axi_master #(.id_bits(4)) mst_d (.clk_i(clk_i),
		.awv_o(awvalid_d_i), .awr_i(awready_d_o), .awid_o(awid_d_i),
		.awa_o(awaddr_d_i), .wv_o(wvalid_d_i), .wr_i(wready_d_o),
		.wd_o(wdata_d_i), .ws_o(wstrb_d_i), .bv_i(bvalid_d_o),
		.br_o(bready_d_i), .bid_i(bid_d_o), .bre_i(bresp_d_o),
		.arv_o(arvalid_d_i), .arr_i(arready_d_o), .arid_o(arid_d_i),
		.ara_o(araddr_d_i), .rv_i(rvalid_d_o), .rr_o(rready_d_i),
		.rid_i(rid_d_o), .rd_i(rdata_d_o), .rre_i(rresp_d_o));
	dsra_axi_master #(.id_bits(3)) mst_c (.clk_i(clk_i),
		.awv_o(awvalid_c_i), .awr_i(awready_c_o), .awid_o(awid_c_i),
		.awa_o(awaddr_c_i), .wv_o(wvalid_c_i), .wr_i(wready_c_o),
		.wd_o(wdata_c_i), .ws_o(wstrb_c_i), .bv_i(bvalid_c_o),
		.br_o(bready_c_i), .bid_i(bid_c_o), .bre_i(bresp_c_o),
		.arv_o(arvalid_c_i), .arr_i(arready_c_o), .arid_o(arid_c_i),
		.ara_o(araddr_c_i), .rv_i(rvalid_c_o), .rr_o(rready_c_i),
		.rid_i(rid_c_o), .rd_i(rdata_c_o), .rre_i(rresp_c_o));

	// Clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			conclude();
		end
	end

	// ==========================================================================
	// Shared tasks
	// ==========================================================================
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input bit c, input logic [3:0] id,
		input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		logic [3:0] i;
		i = 4'h0;
		if (c)
			mst_c.write(id[2:0], a, d, s, r, i[2:0]);
		else
			mst_d.write(id, a, d, s, r, i);
		chk("write resp", 32'(DSRA_RESP_OKAY), 32'(r));
		chk("write id", 32'(id), 32'(i));
	endtask
	task automatic rd(input bit c, input logic [3:0] id,
		input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [1:0] r;
		logic [3:0] i;
		logic [31:0] d;
		i = 4'h0;
		if (c)
			mst_c.read(id[2:0], a, d, r, i[2:0]);
		else
			mst_d.read(id, a, d, r, i);
		chk(what, exp, d);
		chk("read resp", 32'(DSRA_RESP_OKAY), 32'(r));
		chk("read id", 32'(id), 32'(i));
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic t_reset;
		@(negedge clk_i);
		chk("idle outputs", 32'h0, 32'({awready_d_o, arready_d_o, bvalid_d_o,
			rvalid_d_o, wready_c_o, rvalid_c_o, hresp_d_o}));
		chk("ahb ready", 32'h3, 32'({hreadyout_d_o, hreadyout_c_o}));
	endtask
	task automatic t_bank;
		wr(0, 4'h5, 12'h000, 32'h1111_aaaa, 4'hf);
		wr(0, 4'h2, 12'h000, 32'h2222_bbbb, 4'hf);
		wr(0, 4'h4, 12'h000, 32'hdead_beef, 4'hf);
		wr(0, 4'h1, 12'h01c, 32'h7777_0007, 4'hf);
		rd(0, 4'h1, 12'h000, 32'h1111_aaaa, "bank0 word");
		rd(0, 4'h2, 12'h000, 32'h2222_bbbb, "bank1 word");
		rd(0, 4'h4, 12'h000, 32'h0, "unmatched read");
		rd(0, 4'h2, 12'h01c, 32'h0, "other bank top");
		rd(0, 4'h9, 12'h01c, 32'h7777_0007, "masked id top");
	endtask
	task automatic t_shared;
		wr(0, 4'h4, 12'h020, 32'h0bad_cafe, 4'hf);
		wr(0, 4'h4, 12'h020, 32'h1234_5678, 4'h2);
		rd(0, 4'h0, 12'h020, 32'h0bad_56fe, "shared word");
		wr(0, 4'h7, 12'h11c, 32'h0000_011c, 4'hf);
		wr(0, 4'h7, 12'h120, 32'hffff_0120, 4'hf);
		rd(0, 4'h7, 12'h11c, 32'h0000_011c, "last shared");
		rd(0, 4'h7, 12'h120, 32'h0, "unmapped word");
		wr(0, 4'h4, 12'hffc, 32'h0, 4'hf);
		rd(0, 4'h4, 12'hffc, status_d_i, "status word");
	endtask
	task automatic t_cpu;
		fork
			wr(1, 4'h1, 12'h004, 32'hc0c0_0001, 4'hf);
			wr(0, 4'h1, 12'h004, 32'hd0d0_0001, 4'hf);
		join
		rd(1, 4'h1, 12'h004, 32'hc0c0_0001, "cpu bank0");
		rd(1, 4'h2, 12'h004, 32'h0, "cpu bank1");
		rd(0, 4'h1, 12'h004, 32'hd0d0_0001, "dist bank0");
		rd(1, 4'h1, 12'h020, 32'h0, "cpu no shared");
		rd(1, 4'h3, 12'hffc, status_c_i, "cpu status");
	endtask
	task automatic t_overlap;
		mst_d.lag = 2;
		fork
			wr(0, 4'h1, 12'h008, 32'h5555_0008, 4'hf);
			rd(0, 4'h1, 12'h008, 32'h5555_0008, "queued read");
		join
		mst_d.lag = 0;
		rd(0, 4'h1, 12'h008, 32'h5555_0008, "back to back");
	endtask
	task automatic t_ahb;
		@(negedge clk_i);
		{hsel_d_i, hready_d_i, htrans_d_i, hwrite_d_i} = 5'h1d;
		{hsize_d_i, haddr_d_i} = {3'h2, 12'h008};
		@(negedge clk_i);
		{hsize_d_i, haddr_d_i, hwdata_d_i} = {3'h0, 12'h009, 32'ha5a5_0008};
		@(negedge clk_i);
		{hwrite_d_i, hsize_d_i, haddr_d_i} = {1'h0, 3'h2, 12'h008};
		hwdata_d_i = 32'h3c3c_3c3c;
		@(negedge clk_i);
		{hsel_d_i, htrans_d_i} = '0;
		chk("ahb read", 32'ha5a5_3c08, ahb_rdata);
		chk("ahb ready", 32'h1, 32'(ahb_ready));
	endtask

	// Reset, fixed configuration inputs, then the scenarios
	initial begin
		reset_n_i = 1'b0;
		ce_i = 1'b1;
		{hsel_d_i, haddr_d_i, htrans_d_i, hwrite_d_i, hsize_d_i} = '0;
		{hsel_c_i, haddr_c_i, htrans_c_i, hwrite_c_i, hsize_c_i} = '0;
		{hwdata_d_i, hready_d_i, hwdata_c_i, hready_c_i} = '0;
		enable_d_i = {4'hf, 4'h3};
		match_d_i = {4'h2, 4'h1};
		enable_c_i = {3'h7, 3'h7};
		match_c_i = {3'h2, 3'h1};
		status_d_i = 32'h5a5a_1234;
		status_c_i = 32'hc3c3_0f0f;
		repeat (6) @(negedge clk_i);
		reset_n_i = 1'b1;
		t_reset();
		t_bank();
		t_shared();
		t_cpu();
		t_overlap();
		t_ahb();
		conclude();
	end
endmodule // tb
